// ---- common/mas_pkg.sv ----
// Constants, register map and carrier types of the meter and alert block
package mas_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned REBOOT_DELAY_MS = 3200;
  localparam longint unsigned REBOOT_CYCLES =
    longint'(REBOOT_DELAY_MS) * longint'(CLK_HZ / 1000);
  localparam int unsigned REBOOT_CNT_W    = 26;
  localparam int unsigned NVM_WRITE_CYCLES = 200;
  localparam int unsigned NVM_CNT_W       = 16;

  // Widths
  localparam int unsigned ENERGY_W  = 48;
  localparam int unsigned CYCLE_W   = 32;
  localparam int unsigned SAMPLE_W  = 24;
  localparam int unsigned ENERGY_BYTES = 6;
  localparam int unsigned CYCLE_BYTES  = 4;

  // Register offsets
  localparam logic [7:0] ADDR_ENERGY = 8'h12;
  localparam logic [7:0] ADDR_CYCLES = 8'h18;
  localparam logic [7:0] ADDR_ALERT  = 8'h1c;
  localparam logic [7:0] ADDR_CTRL   = 8'h1d;
  localparam logic [7:0] ADDR_STAT0  = 8'h1e;
  localparam logic [7:0] ADDR_STAT1  = 8'h1f;
  localparam logic [7:0] ADDR_IMG0   = 8'h20;
  localparam logic [7:0] ADDR_IMG1   = 8'h21;

  // Field positions
  localparam int unsigned ALERT_GEN_BIT = 7;
  localparam int unsigned ALERT_PIN_PULLDOWN_BIT  = 6;
  localparam int unsigned REBOOT_BIT    = 7;
  localparam int unsigned MRST_BIT      = 6;
  localparam int unsigned MHALT_BIT     = 5;
  localparam int unsigned FLOG_BIT      = 2;
  localparam int unsigned GATE_BIT      = 1;
  localparam int unsigned CHALT_BIT     = 0;
  localparam int unsigned IMG_FMASK_BIT = 7;
  localparam int unsigned IMG_ON_BIT    = 3;

  // Reset values
  localparam logic [7:0] IMG0_RST = 8'hbb;
  localparam logic [7:0] IMG1_RST = 8'h02;

  typedef enum logic [1:0] {MAS_BOOT, MAS_RUN, MAS_OFF} mas_phase_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } mas_reg_req_t;

  typedef struct packed {
    logic fet_cooling;
    logic shorted;
    logic power_good;
    logic oc_cooling;
    logic in_low;
    logic in_high;
  } mas_core_flags_t;

  typedef struct packed {
    logic gp3;
    logic gp2;
    logic gp1;
    logic alert;
    logic en;
  } mas_pins_t;
endpackage

// ---- hdl/mas_meter_alert_status_regs.sv ----
// Meter, alert, converter control, status and boot image register block
`timescale 1ns/1ps

// What this block does
// (R1) Six-byte energy accumulator at 0x12-0x17, read/write, zero at reset.
// (R2) Four-byte conversion cycle counter at 0x18-0x1B.
// (R3) Alert flag set on any alert, cleared only by writing zero.
// (R4) Host writing one to the alert flag acts as a real alert.
// (R5) Pull-down bit drives the alert pin low.
// (R6) Reboot bit turns off, reloads boot image, restarts after 3.2 s.
// (R7) Meter reset bit holds accumulator and counter at zero.
// (R8) Meter halt bit freezes accumulator and counter.
// (R9) Fault log enable copies 0x04 and 0x05 to memory on fault rise.
// (R10) Bit 1 of 0x1D reads gate level, read only.
// (R11) Halt set: each rewrite with halt starts one conversion.
// (R12) Status byte 0x1E shows switch, fault, pin and supply states.
// (R13) Status 0x1F bits 7-4 show pin levels.
// (R14) Memory busy bit high through every nonvolatile write.
// (R15) Converter idle flag zero when free running, one when idle.
// (R16) Status bits show counter and accumulator wrap.
// (R17) Image bit 7 sets fault mask default and restores fault log.
// (R18) Image bit 3 picks power-up switch: off or follow enable.
// (R19) Image bits 2-0 hold retry default, factory 011.
// (R20) Image byte 0x21 holds boot default of control 0x01, 0x02.
// (R21) Reserved bits of 0x1C and 0x1D read zero.
// (R22) Charge mode accumulates current instead of power.
// (R23) Each result adds to accumulator, counts, and flags wrap.
// (R24) Live controls load from image before switch or converter run.
module mas_meter_alert_status_regs #(
  parameter longint unsigned REBOOT_CYCLES = mas_pkg::REBOOT_CYCLES,
  parameter int unsigned     NVM_CYCLES    = mas_pkg::NVM_WRITE_CYCLES
) (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire mas_pkg::mas_reg_req_t     reg_req,
  output logic [7:0]                     reg_rdata,
  output logic                           reg_rvalid,
  input  wire logic                      result_valid,
  input  wire logic [mas_pkg::SAMPLE_W-1:0] power_result,
  input  wire logic [mas_pkg::SAMPLE_W-1:0] current_result,
  input  wire logic                      charge_mode,
  input  wire logic                      alert_event,
  input  wire logic                      gate_level_flag,
  input  wire mas_pkg::mas_core_flags_t  core_flags,
  input  wire mas_pkg::mas_pins_t        pins_in,
  input  wire logic [7:0]                fault_log_byte,
  input  wire logic [7:0]                adc_alert_log_byte,
  input  wire logic [7:0]                nvm_img0,
  input  wire logic [7:0]                nvm_img1,
  input  wire logic [7:0]                stored_fault_record,
  output logic                           alert_pin_out,
  output logic                           alert_pin_oe,
  output logic                           switch_on,
  output logic                           conv_run,
  output logic                           conv_start,
  output logic [7:0]                     live_ctrl0,
  output logic [7:0]                     live_ctrl1,
  output logic                           fault_log_restore,
  output logic [7:0]                     restore_data,
  output logic                           nvm_write,
  output logic [15:0]                    nvm_wdata
);

  typedef struct packed {
    mas_pkg::mas_phase_t phase;
    mas_pkg::mas_pins_t  pin_s1;
    mas_pkg::mas_pins_t  pin_s2;
    mas_pkg::mas_pins_t  pin_s3;
    mas_pkg::mas_pins_t  pin_f;
    logic [mas_pkg::ENERGY_W-1:0] energy;
    logic [mas_pkg::CYCLE_W-1:0]  cycles;
    logic        e_wrap;
    logic        c_wrap;
    logic        alert_gen;
    logic        alert_pin_pulldown;
    logic        m_rst;
    logic        m_halt;
    logic        log_en;
    logic        conv_halt;
    logic        conv_busy;
    logic        conv_start;
    logic [7:0]  img0;
    logic [7:0]  img1;
    logic [7:0]  live0;
    logic [7:0]  live1;
    logic        switch_on;
    logic        conv_run;
    logic        restore;
    logic [7:0]  restore_data;
    logic [7:0]  fault_prev;
    logic        nvm_wr;
    logic [15:0] nvm_data;
    logic [mas_pkg::NVM_CNT_W-1:0]    nvm_cnt;
    logic [mas_pkg::REBOOT_CNT_W-1:0] reboot_cnt;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        alert_oe;
  } mas_state_t;

  mas_state_t s;
  mas_state_t next_s;
  logic       rst_s1;
  logic       rst_n;
  logic [15:0] stat_w;

  localparam logic [mas_pkg::REBOOT_CNT_W-1:0] REBOOT_LAST =
    mas_pkg::REBOOT_CNT_W'(REBOOT_CYCLES - 1);
  localparam logic [mas_pkg::NVM_CNT_W-1:0] NVM_LOAD =
    mas_pkg::NVM_CNT_W'(NVM_CYCLES);

  // Byte k of a wide value, most significant byte at the lowest offset
  function automatic logic [7:0] byte_of(input logic [63:0] v,
                                         input logic [2:0]  k,
                                         input logic [2:0]  nbytes);
    logic [2:0] pos;
    pos = 3'(nbytes - 3'd1 - k);
    return v[{pos, 3'b000} +: 8];
  endfunction

  // Status word, both bytes, from live state
  function automatic logic [15:0] status_word(
    input mas_state_t st, input mas_pkg::mas_core_flags_t cf);
    return {st.switch_on, cf.fet_cooling, cf.shorted, st.pin_f.en,
            cf.power_good, cf.oc_cooling, cf.in_low, cf.in_high,
            st.pin_f.gp3, st.pin_f.gp2, st.pin_f.gp1, st.pin_f.alert,
            st.nvm_cnt != '0, st.conv_halt & ~st.conv_busy,
            st.c_wrap, st.e_wrap};
  endfunction

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  always_comb begin
    logic [7:0]  a;
    logic        wr;
    logic [7:0]  wd;
    logic [mas_pkg::ENERGY_W:0] esum;
    logic [mas_pkg::CYCLE_W:0]  csum;
    logic [mas_pkg::SAMPLE_W-1:0] sample;
    logic        fault_rise;
    logic [2:0]  k;
    a = reg_req.addr;
    wr = reg_req.wr;
    wd = reg_req.wdata;
    esum = '0;
    csum = '0;
    sample = '0;
    fault_rise = 1'b0;
    k = '0;
    next_s = s;
    next_s.conv_start = 1'b0;
    next_s.restore = 1'b0;
    next_s.nvm_wr = 1'b0;
    next_s.rvalid = 1'b0;

    // Pin sync; first stage feeds only the second
    next_s.pin_s1 = pins_in;
    next_s.pin_s2 = s.pin_s1;
    next_s.pin_s3 = s.pin_s2;
    if (s.pin_s2 == s.pin_s3) begin
      next_s.pin_f = s.pin_s3; // R13
    end

    // Accumulate one result per completed conversion
    sample = charge_mode ? current_result : power_result; // R22
    if (s.m_rst) begin
      next_s.energy = '0; // R7
      next_s.cycles = '0; // R7
      next_s.e_wrap = 1'b0;
      next_s.c_wrap = 1'b0;
    end else if (result_valid && !s.m_halt && s.phase == mas_pkg::MAS_RUN)
    begin
      esum = {1'b0, s.energy} + (mas_pkg::ENERGY_W + 1)'(sample);
      csum = {1'b0, s.cycles} + (mas_pkg::CYCLE_W + 1)'(1);
      next_s.energy = esum[mas_pkg::ENERGY_W-1:0]; // R23
      next_s.cycles = csum[mas_pkg::CYCLE_W-1:0]; // R2
      if (esum[mas_pkg::ENERGY_W]) begin
        next_s.e_wrap = 1'b1; // R16
      end
      if (csum[mas_pkg::CYCLE_W]) begin
        next_s.c_wrap = 1'b1; // R16
      end
    end

    // Converter finishing a conversion frees the single shot
    if (result_valid) begin
      next_s.conv_busy = 1'b0;
    end

    // Register writes beat accumulation; meter reset beats both
    if (wr && s.phase == mas_pkg::MAS_RUN) begin
      if (a >= mas_pkg::ADDR_ENERGY && a < mas_pkg::ADDR_CYCLES) begin
        k = 3'(a - mas_pkg::ADDR_ENERGY);
        next_s.energy[{3'(3'd5 - k), 3'b000} +: 8] = wd; // R1
      end else if (a >= mas_pkg::ADDR_CYCLES && a < mas_pkg::ADDR_ALERT)
      begin
        k = 3'(a - mas_pkg::ADDR_CYCLES);
        next_s.cycles[{2'(2'd3 - k[1:0]), 3'b000} +: 8] = wd; // R2
      end else if (a == mas_pkg::ADDR_ALERT) begin
        next_s.alert_gen = wd[mas_pkg::ALERT_GEN_BIT]; // R3 R4
        next_s.alert_pin_pulldown = wd[mas_pkg::ALERT_PIN_PULLDOWN_BIT];
      end else if (a == mas_pkg::ADDR_CTRL) begin
        next_s.m_rst = wd[mas_pkg::MRST_BIT];
        next_s.m_halt = wd[mas_pkg::MHALT_BIT]; // R8
        next_s.log_en = wd[mas_pkg::FLOG_BIT];
        next_s.conv_halt = wd[mas_pkg::CHALT_BIT];
        // Rewrite with halt already set fires one conversion
        if (s.conv_halt && wd[mas_pkg::CHALT_BIT]) begin
          next_s.conv_start = 1'b1; // R11
          next_s.conv_busy = 1'b1; // R15
        end
        if (wd[mas_pkg::REBOOT_BIT]) begin
          next_s.phase = mas_pkg::MAS_OFF; // R6
          next_s.reboot_cnt = '0;
        end
      end else if (a == mas_pkg::ADDR_IMG0 || a == mas_pkg::ADDR_IMG1) begin
        // Image writes go straight to memory, busy meanwhile
        if (a == mas_pkg::ADDR_IMG0) begin
          next_s.img0 = wd; // R17 R18 R19
        end else begin
          next_s.img1 = wd; // R20
        end
        next_s.nvm_wr = 1'b1;
        next_s.nvm_data = (a == mas_pkg::ADDR_IMG0) ? {wd, s.img1}
                                                    : {s.img0, wd};
        next_s.nvm_cnt = NVM_LOAD; // R14
      end
    end
    if (s.m_rst) begin
      next_s.energy = '0; // R7
      next_s.cycles = '0; // R7
    end

    // Alert events set the flag after the host write: set wins
    if (alert_event) begin
      next_s.alert_gen = 1'b1; // R3
    end
    next_s.alert_oe = next_s.alert_gen | next_s.alert_pin_pulldown; // R4 R5

    // Fault log copy on any rising fault bit
    fault_rise = |(fault_log_byte & ~s.fault_prev);
    next_s.fault_prev = fault_log_byte;
    if (fault_rise && s.log_en && s.phase == mas_pkg::MAS_RUN &&
        !next_s.nvm_wr) begin
      next_s.nvm_wr = 1'b1; // R9
      next_s.nvm_data = {fault_log_byte, adc_alert_log_byte}; // R9
      next_s.nvm_cnt = NVM_LOAD; // R14
    end else if (!next_s.nvm_wr && s.nvm_cnt != '0) begin
      next_s.nvm_cnt = s.nvm_cnt - 1'b1;
    end

    // Boot, run and reboot sequencing
    case (s.phase)
      mas_pkg::MAS_BOOT: begin
        next_s.img0 = nvm_img0;
        next_s.img1 = nvm_img1;
        next_s.live0 = nvm_img0; // R24
        next_s.live1 = nvm_img1; // R20
        next_s.restore = nvm_img0[mas_pkg::IMG_FMASK_BIT]; // R17
        next_s.restore_data = stored_fault_record;
        next_s.m_rst = 1'b0;
        next_s.m_halt = 1'b0;
        next_s.log_en = 1'b0;
        next_s.conv_halt = 1'b0;
        next_s.conv_busy = 1'b0;
        next_s.phase = mas_pkg::MAS_RUN;
      end
      mas_pkg::MAS_RUN: begin
        next_s.switch_on = s.live0[mas_pkg::IMG_ON_BIT] & s.pin_f.en; // R18
        next_s.conv_run = ~next_s.conv_halt; // R11
        if (next_s.phase == mas_pkg::MAS_OFF) begin
          next_s.switch_on = 1'b0; // R6
          next_s.conv_run = 1'b0;
        end
      end
      mas_pkg::MAS_OFF: begin
        next_s.switch_on = 1'b0; // R6
        next_s.conv_run = 1'b0;
        next_s.conv_start = 1'b0;
        next_s.reboot_cnt = s.reboot_cnt + 1'b1;
        if (s.reboot_cnt == REBOOT_LAST) begin
          next_s.phase = mas_pkg::MAS_BOOT; // R6
        end
      end
      default: begin
        next_s.phase = mas_pkg::MAS_BOOT;
      end
    endcase

    // Read data, registered; unmapped offsets read zero
    if (reg_req.rd) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = 8'h00;
      if (a >= mas_pkg::ADDR_ENERGY && a < mas_pkg::ADDR_CYCLES) begin
        next_s.rdata = byte_of(64'(s.energy), 3'(a - mas_pkg::ADDR_ENERGY),
                               3'(mas_pkg::ENERGY_BYTES)); // R1
      end else if (a >= mas_pkg::ADDR_CYCLES && a < mas_pkg::ADDR_ALERT)
      begin
        next_s.rdata = byte_of(64'(s.cycles), 3'(a - mas_pkg::ADDR_CYCLES),
                               3'(mas_pkg::CYCLE_BYTES)); // R2
      end else if (a == mas_pkg::ADDR_ALERT) begin
        next_s.rdata = {s.alert_gen, s.alert_pin_pulldown, 6'b00_0000}; // R21
      end else if (a == mas_pkg::ADDR_CTRL) begin
        next_s.rdata = {1'b0, s.m_rst, s.m_halt, 2'b00, s.log_en,
                        gate_level_flag, s.conv_halt}; // R10 R21
      end else if (a == mas_pkg::ADDR_STAT0) begin
        next_s.rdata = stat_w[15:8]; // R12
      end else if (a == mas_pkg::ADDR_STAT1) begin
        next_s.rdata = stat_w[7:0]; // R13 R15 R16
      end else if (a == mas_pkg::ADDR_IMG0) begin
        next_s.rdata = s.img0;
      end else if (a == mas_pkg::ADDR_IMG1) begin
        next_s.rdata = s.img1;
      end
    end
  end

  // Whole state in one register; boot image loads after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.phase <= mas_pkg::MAS_BOOT;
      s.img0 <= mas_pkg::IMG0_RST;
      s.img1 <= mas_pkg::IMG1_RST;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state flops; alert pin output tied low
  assign reg_rdata         = s.rdata;
  assign reg_rvalid        = s.rvalid;
  assign alert_pin_out     = 1'b0;
  assign alert_pin_oe      = s.alert_oe;
  assign switch_on         = s.switch_on;
  assign conv_run          = s.conv_run;
  assign conv_start        = s.conv_start;
  assign live_ctrl0        = s.live0;
  assign live_ctrl1        = s.live1;
  assign fault_log_restore = s.restore;
  assign restore_data      = s.restore_data;
  assign nvm_write         = s.nvm_wr;
  assign nvm_wdata         = s.nvm_data;
  assign stat_w            = status_word(s, core_flags);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_alert_sets_flag: assert property ( // R3
    alert_event |=> s.alert_gen)
    else $error("alert event did not set flag");
  chk_alert_pin_low: assert property ( // R5
    s.alert_pin_pulldown |-> alert_pin_oe && !alert_pin_out)
    else $error("alert pull-down not driving pin");
  chk_flag_drives_pin: assert property ( // R4
    s.alert_gen |-> alert_pin_oe)
    else $error("alert flag not driving pin");
  chk_meter_held_zero: assert property ( // R7
    s.m_rst ##1 s.m_rst |-> s.energy == '0 && s.cycles == '0)
    else $error("meter not held at zero");
  chk_meter_frozen: assert property ( // R8
    s.m_halt && !s.m_rst && !reg_req.wr |=>
      $stable(s.energy) && $stable(s.cycles))
    else $error("meter moved while halted");
  chk_count_step: assert property ( // R23
    result_valid && !s.m_halt && !s.m_rst && !reg_req.wr &&
      s.phase == mas_pkg::MAS_RUN |=> s.cycles == $past(s.cycles) + 1)
    else $error("cycle counter missed a result");
  chk_busy_write: assert property ( // R14
    nvm_write |=> (s.nvm_cnt != '0) [*3])
    else $error("memory busy dropped early");
  chk_idle_free_run: assert property ( // R15
    !s.conv_halt |-> !stat_w[2])
    else $error("idle flag set while free running");
  chk_single_shot: assert property ( // R11
    reg_req.wr && reg_req.addr == mas_pkg::ADDR_CTRL && s.conv_halt &&
      reg_req.wdata[mas_pkg::CHALT_BIT] && !reg_req.wdata[mas_pkg::REBOOT_BIT]
      && s.phase == mas_pkg::MAS_RUN ##1 !reg_req.wr |-> conv_start ##1
      !conv_start)
    else $error("single shot start missing");
  chk_reboot_off: assert property ( // R6
    s.phase == mas_pkg::MAS_OFF |-> !switch_on && !conv_run)
    else $error("switch on during reboot");
  chk_boot_load: assert property ( // R24
    s.phase == mas_pkg::MAS_BOOT |=> live_ctrl0 == $past(nvm_img0))
    else $error("live control not loaded at boot");

  cov_reboot: cover property (s.phase == mas_pkg::MAS_OFF);
  cov_energy_wrap: cover property ($rose(s.e_wrap));
  cov_fault_log: cover property (nvm_write && s.log_en);
  cov_one_shot: cover property (conv_start);
endmodule

// ---- tb/mas_host_model.sv ----
// Host-side model that drives the register byte port
`timescale 1ns/1ps
module mas_host_model (
  input  wire logic             clk,
  output mas_pkg::mas_reg_req_t reg_req,
  input  wire logic [7:0]       reg_rdata,
  input  wire logic             reg_rvalid
);
  int unsigned tmo;

  initial reg_req = '0;

  // One strobe per request; address and data scrambled while idle
  task automatic put(input logic [7:0] a, input logic [7:0] d,
                     input logic w);
    @(negedge clk);
    reg_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(negedge clk);
    reg_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    put(a, d, 1'b1);
  endtask

  // Read data is taken in the cycle that flags it valid, or after four cycles without it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    put(a, 8'h00, 1'b0);
    tmo = 0;
    while (reg_rvalid !== 1'b1 && tmo < 4) begin
      @(negedge clk);
      tmo++;
    end
    d = reg_rdata;
  endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the meter, alert and status register block
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned NVMC = 5;
  logic                     clk = 1'b0;
  logic                     nrst = 1'b0;
  logic                     res_v = 1'b0;
  logic                     chg = 1'b0;
  logic                     alev = 1'b0;
  logic                     gate = 1'b1;
  logic [23:0]              pwr = '0;
  logic [23:0]              cur = '0;
  mas_pkg::mas_core_flags_t cf = '0;
  mas_pkg::mas_pins_t       pins = '0;
  logic [7:0]               flog = '0;
  logic [7:0]               alog = '0;
  logic [7:0]               img0 = '0;
  logic [7:0]               img1 = '0;
  logic [7:0]               sfr = '0;
  mas_pkg::mas_reg_req_t    req;
  logic [7:0]               rdata, lc0, lc1, rsd, b;
  logic                     rvld, aoe, swon, crun, cst, nvw, apo, flr;
  logic                     flr_seen = 1'b0;
  logic [15:0]              nvd, st;
  logic [47:0]              e_exp, v;
  logic [31:0]              c_exp;
  int                       failures = 0;
  int                       compares = 0;
  int                       seed = 3143;
  int                       n;

  always #25 clk = ~clk;

  // Boot restore pulse lasts one cycle; remember that it came
  always @(negedge clk) begin
    if (flr) begin
      flr_seen <= 1'b1;
    end
  end

  // Short reboot and memory counts keep the run brief
  mas_meter_alert_status_regs #(.REBOOT_CYCLES(20), .NVM_CYCLES(NVMC))
  mas_meter_alert_status_regs_i (
    .clk(clk), .nrst(nrst), .reg_req(req), .reg_rdata(rdata),
    .reg_rvalid(rvld), .result_valid(res_v), .power_result(pwr),
    .current_result(cur), .charge_mode(chg), .alert_event(alev),
    .gate_level_flag(gate), .core_flags(cf), .pins_in(pins),
    .fault_log_byte(flog), .adc_alert_log_byte(alog), .nvm_img0(img0),
    .nvm_img1(img1), .stored_fault_record(sfr), .alert_pin_out(apo),
    .alert_pin_oe(aoe), .switch_on(swon), .conv_run(crun),
    .conv_start(cst), .live_ctrl0(lc0), .live_ctrl1(lc1),
    .fault_log_restore(flr), .restore_data(rsd), .nvm_write(nvw),
    .nvm_wdata(nvd));

  mas_host_model mas_host_model_i (
    .clk(clk), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvld));

  task automatic give_verdict();
    if (failures == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Multi-byte access, lowest offset carries the top byte
  task automatic rdn(input logic [7:0] a, input int cnt);
    v = '0;
    for (int i = 0; i < cnt; i++) begin
      mas_host_model_i.rd(a + 8'(i), b);
      if (mas_host_model_i.tmo >= 4) begin
        chk(48'h0, 48'h1);
        give_verdict();
      end
      v = {v[39:0], b};
    end
  endtask

  task automatic wrn(input logic [7:0] a, input int cnt,
                     input logic [47:0] d);
    for (int i = 0; i < cnt; i++) begin
      mas_host_model_i.wr(a + 8'(i), d[8*(cnt-1-i) +: 8]);
    end
  endtask

  task automatic pulse(input logic [23:0] p, input logic [23:0] c);
    @(negedge clk);
    pwr <= p;
    cur <= c;
    res_v <= 1'b1;
    @(negedge clk);
    res_v <= 1'b0;
  endtask

  // Bounded wait on a design strobe; a miss ends the run
  task automatic wait_hi(input int which);
    n = 0;
    while ((which ? nvw : cst) !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    if (n >= 4) begin
      chk(48'h0, 48'h1);
      give_verdict();
    end
  endtask

  initial begin
    img0 = 8'($random(seed)) | 8'h88;
    img1 = 8'($random(seed));
    sfr = 8'($random(seed));
    alog = 8'($random(seed));
    cf = 6'($random(seed));
    pins = 5'($random(seed)) | 5'h01;
    repeat (2) @(negedge clk);
    nrst <= 1'b1;
    repeat (8) @(negedge clk);
    chk(lc0, img0);
    chk(lc1, img1);
    chk(rsd, sfr);
    chk(flr_seen, img0[7]);
    chk(swon, 1'b1);
    rdn(8'h12, 6);
    chk(v, 48'h0);
    rdn(8'h18, 4);
    chk(v, 48'h0);
    rdn(8'h3f, 1);
    chk(v, 48'h0);
    st = {1'b1, cf.fet_cooling, cf.shorted, pins.en, cf.power_good,
          cf.oc_cooling, cf.in_low, cf.in_high, pins.gp3, pins.gp2,
          pins.gp1, pins.alert, 4'h0};
    rdn(8'h1e, 2);
    chk(v, 48'(st));
    // Random load, then results in power and charge mode
    e_exp = {16'($random(seed)), 32'($random(seed))};
    c_exp = 32'($random(seed));
    wrn(8'h12, 6, e_exp);
    wrn(8'h18, 4, 48'(c_exp));
    for (int k = 0; k < 4; k++) begin
      chg <= k[1];
      pulse(24'($random(seed)), 24'($random(seed)));
      e_exp += 48'(k[1] ? cur : pwr);
      c_exp++;
    end
    rdn(8'h12, 6);
    chk(v, e_exp);
    rdn(8'h18, 4);
    chk(v, 48'(c_exp));
    mas_host_model_i.wr(8'h1d, 8'h20);
    pulse(24'h00_0fff, 24'h00_0fff);
    rdn(8'h12, 6);
    chk(v, e_exp);
    rdn(8'h1d, 1);
    chk(v, 48'h22);
    gate <= 1'b0;
    rdn(8'h1d, 1);
    chk(v, 48'h20);
    gate <= 1'b1;
    mas_host_model_i.wr(8'h1d, 8'h40);
    pulse(24'h00_0fff, 24'h00_0fff);
    rdn(8'h12, 6);
    chk(v, 48'h0);
    rdn(8'h18, 4);
    chk(v, 48'h0);
    mas_host_model_i.wr(8'h1d, 8'h00);
    chg <= 1'b0;
    wrn(8'h12, 6, '1);
    wrn(8'h18, 4, '1);
    pulse(24'h00_0001, 24'h00_0000);
    rdn(8'h12, 6);
    chk(v, 48'h0);
    rdn(8'h1f, 1);
    chk(48'(v[1:0]), 48'h3);
    // Alert flag and pull-down drive the pin
    mas_host_model_i.wr(8'h1c, 8'h40);
    @(negedge clk);
    chk(aoe, 1'b1);
    chk(apo, 1'b0);
    rdn(8'h1c, 1);
    chk(v, 48'h40);
    mas_host_model_i.wr(8'h1c, 8'h00);
    @(negedge clk);
    chk(aoe, 1'b0);
    alev <= 1'b1;
    @(negedge clk);
    alev <= 1'b0;
    rdn(8'h1c, 1);
    chk(v, 48'h80);
    chk(aoe, 1'b1);
    mas_host_model_i.wr(8'h1c, 8'h00);
    rdn(8'h1c, 1);
    chk(v, 48'h00);
    mas_host_model_i.wr(8'h1c, 8'h80);
    rdn(8'h1c, 1);
    chk(v, 48'h80);
    chk(aoe, 1'b1);
    mas_host_model_i.wr(8'h1c, 8'h00);
    // Single-shot conversions
    mas_host_model_i.wr(8'h1d, 8'h01);
    repeat (2) @(negedge clk);
    chk(crun, 1'b0);
    rdn(8'h1f, 1);
    chk(48'(v[2]), 48'h1);
    mas_host_model_i.wr(8'h1d, 8'h01);
    wait_hi(0);
    @(negedge clk);
    chk(cst, 1'b0);
    rdn(8'h1f, 1);
    chk(48'(v[2]), 48'h0);
    pulse(24'h00_0001, 24'h00_0001);
    rdn(8'h1f, 1);
    chk(48'(v[2]), 48'h1);
    mas_host_model_i.wr(8'h1d, 8'h00);
    rdn(8'h1f, 1);
    chk(48'(v[2]), 48'h0);
    chk(crun, 1'b1);
    // Fault log copy and memory busy window
    mas_host_model_i.wr(8'h1d, 8'h04);
    flog <= 8'($random(seed)) | 8'h01;
    wait_hi(1);
    chk(nvd, {flog, alog});
    rdn(8'h1f, 1);
    chk(48'(v[3]), 48'h1);
    repeat (NVMC + 4) @(negedge clk);
    rdn(8'h1f, 1);
    chk(48'(v[3]), 48'h0);
    wrn(8'h20, 2, 48'h5a_c3);
    rdn(8'h20, 2);
    chk(v, 48'h5a_c3);
    // Reboot turns off, then reloads from the stored image
    mas_host_model_i.wr(8'h1d, 8'h80);
    @(negedge clk);
    chk(swon, 1'b0);
    chk(crun, 1'b0);
    repeat (40) @(negedge clk);
    chk(lc0, img0);
    chk(swon, 1'b1);
    rdn(8'h1d, 1);
    chk(48'(v[7]), 48'h0);
    give_verdict();
  end
endmodule
